// ### logic/gpf_pkg.sv
// gpf package: constants shared by the pin bank and its generators
package gpf_pkg;
    // bank geometry
    localparam int NPINS = 19;
    localparam int PWM_MAX_PINS = 12;
    localparam int FIX_OUTS = 2;
    localparam int PER_W = 24;
    localparam int ADDR_W = 8;

    // timing: clock rate and fastest outputs, periods rounded up to whole cycles
    localparam int CLK_HZ = 20_000_000;
    localparam int PWM_MAX_HZ = 1_000_000;
    localparam int FIX_MAX_HZ = 4_000_000;
    localparam int PWM_MIN_PER = (CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ;
    localparam int FIX_MIN_PER = (CLK_HZ + FIX_MAX_HZ - 1) / FIX_MAX_HZ;

    // analog figures, informational only (pads take the select bits)
    localparam int DRV_STD_UA = 500;
    localparam int DRV_HIGH_UA = 5000;
    localparam int PULL_KOHM = 13;

    // register byte offsets
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_OUT = 8'h04;
    localparam logic [7:0] OFS_IN = 8'h08;
    localparam logic [7:0] OFS_DRIVE = 8'h0C;
    localparam logic [7:0] OFS_PULLUP = 8'h10;
    localparam logic [7:0] OFS_PULLDN = 8'h14;
    localparam logic [7:0] OFS_WAKE_EN = 8'h18;
    localparam logic [7:0] OFS_WAKE_POL = 8'h1C;
    localparam logic [7:0] OFS_PIN_FUNC_PWM = 8'h20;
    localparam logic [7:0] OFS_PWM_PERIOD = 8'h24;
    localparam logic [7:0] OFS_PWM_HIGH = 8'h28;
    localparam logic [7:0] OFS_FIX_PERIOD = 8'h2C;
    localparam logic [7:0] OFS_FIX_SEL = 8'h30;
    localparam logic [7:0] OFS_FIX_DUTY_A = 8'h34;
    localparam logic [7:0] OFS_FIX_DUTY_B = 8'h38;
    localparam logic [7:0] OFS_WAKE_STAT = 8'h3C;
    localparam logic [7:0] OFS_WAKE_MASK = 8'h40;

    // field positions
    localparam int FSEL_EN = 5;
    localparam int FSEL_B_LSB = 8;
    localparam int DUTY_CUS = 31;

    // values after reset
    localparam logic [NPINS-1:0] RST_PINS = 19'h0_0000;
    localparam logic [PER_W-1:0] RST_PER = 24'h00_0000;
    localparam logic [5:0] RST_FSEL = 6'h00;
endpackage

// ### logic/gpf_pwm.sv
// gpf_pwm: single pulse width generator shared by up to 12 pins at once
`timescale 1ns/1ps
module gpf_pwm
    import gpf_pkg::*;
#(
    parameter int W = PER_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] period,
    input wire logic [W-1:0] high,
    output logic pwm_o
);
    localparam logic [W-1:0] MINP = W'(PWM_MIN_PER);
    logic [W-1:0] eff;
    logic [W-1:0] cnt_r;
    logic [W-1:0] per_r;
    logic [W-1:0] high_r;
    logic wrap;

    // short periods clamp to the fastest legal rate
    assign eff = (per_r < MINP) ? MINP : per_r; // [RQ6]
    assign wrap = (cnt_r >= eff - 1'b1);

    // settings taken at period end so a rewrite never cuts a pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            per_r <= '0;
            high_r <= '0;
        end else if (wrap) begin
            per_r <= period;
            high_r <= high;
        end
    end

    // free running period counter
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (wrap) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // high 0 gives constant low, high >= clamped period constant high
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= (cnt_r < high_r); // [RQ7]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    pwm_low_a: assert property ((high_r == '0) [*2] |-> !pwm_o) // [RQ7]
        else $error("pwm not low at zero duty");
    pwm_full_a: assert property ((high_r >= eff) [*2] |-> pwm_o) // [RQ7]
        else $error("pwm not high at full duty");
    pwm_wrap_a: assert property ($rose(pwm_o) |-> cnt_r == W'(1) && eff >= MINP) // [RQ6]
        else $error("pwm edge off period start");
endmodule

// ### logic/gpf_fixout.sv
// gpf_fixout: shared-rate square wave with independent duty per output
`timescale 1ns/1ps
module gpf_fixout
    import gpf_pkg::*;
#(
    parameter int W = PER_W,
    parameter int N = FIX_OUTS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] period,
    input wire logic [N-1:0] cus,
    input wire logic [N-1:0][W-1:0] high,
    output logic [N-1:0] fix_o
);
    localparam logic [W-1:0] MINP = W'(FIX_MIN_PER);
    logic [W-1:0] eff;
    logic [W-1:0] cnt_r;
    logic [W-1:0] per_r;
    logic [N-1:0] cus_r;
    logic [N-1:0][W-1:0] high_r;
    logic reload;

    assign eff = (per_r < MINP) ? MINP : per_r; // [RQ10]
    // new settings at a period end, or at once while stopped
    assign reload = (per_r == '0) || (cnt_r >= eff - 1'b1);

    // settings held a whole period so no edge lands mid-period
    always_ff @(posedge clk) begin
        if (rst) begin
            per_r <= '0;
            cus_r <= '0;
            high_r <= '0;
        end else if (reload) begin
            per_r <= period;
            cus_r <= cus;
            high_r <= high;
        end
    end

    // one counter for all outputs keeps them on one rate; zero period parks it
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (reload) begin // [RQ12]
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1; // [RQ9]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    for (genvar i = 0; i < N; i++) begin : g_out
        logic [W-1:0] thr;
        // default waveform is high for half the clamped period, rounded down, then low
        assign thr = cus_r[i] ? high_r[i] : (eff >> 1); // [RQ9] [RQ10]
        always_ff @(posedge clk) begin
            if (rst) begin
                fix_o[i] <= 1'b0;
            end else begin
                fix_o[i] <= (per_r != '0) && (cnt_r < thr); // [RQ12]
            end
        end
        fix_rise_a: assert property ($rose(fix_o[i]) |-> cnt_r == W'(1)) // [RQ9]
            else $error("output rose off shared period start");
        fix_half_a: assert property (($fell(fix_o[i]) && !cus_r[i]) |-> // [RQ10]
                cnt_r == (eff >> 1) + W'(1))
            else $error("default duty not half");
    end

    fix_stop_a: assert property ((per_r == '0) [*2] |-> fix_o == '0) // [RQ12]
        else $error("output moves at zero rate");
endmodule

// ### logic/gpf_bank.sv
// gpf_bank: 19-pin bank with AHB-Lite registers, wake status and two generators
//
// Contract
// [RQ1] 19 pins, each with its own direction and settings.
// [RQ2] each output pin selects standard or high drive strength.
// [RQ3] each pin selects pull-up, pull-down or no pull.
// [RQ4] every pin can wake on a chosen high or low level.
// [RQ5] pulse width output routable to output pins, at most 12 at once.
// [RQ6] pulse width frequency programmable, never faster than 1 MHz.
// [RQ7] pulse width duty programmable from constant low to constant high.
// [RQ8] fixed-rate output routable to at most two pins.
// [RQ9] both fixed-rate pins share one rate, each has its own duty.
// [RQ10] fixed rate from 0 Hz to 4 MHz, default duty half.
// [RQ11] a selected generator drives the pin instead of the output value.
// [RQ12] fixed rate of zero holds the pin static with no edges.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module gpf_bank
    import gpf_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [NPINS-1:0] PIN_IN,
    output logic [NPINS-1:0] PIN_OUT,
    output logic [NPINS-1:0] PIN_OE,
    output logic [NPINS-1:0] PIN_HIDRIVE,
    output logic [NPINS-1:0] PIN_PULLUP,
    output logic [NPINS-1:0] PIN_PULLDN,
    output logic IRQ,
    output logic WAKE
);
    // bus state
    logic acc;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [ADDR_W-1:0] adr_r;
    logic [31:0] rdata;

    // pin configuration
    logic [NPINS-1:0] dir_r;
    logic [NPINS-1:0] out_r;
    logic [NPINS-1:0] drv_r;
    logic [NPINS-1:0] pu_r;
    logic [NPINS-1:0] pd_r;
    logic [NPINS-1:0] wen_r;
    logic [NPINS-1:0] wpol_r;
    logic [NPINS-1:0] pwm_sel_r;

    // generator settings
    logic [PER_W-1:0] pwm_per_r;
    logic [PER_W-1:0] pwm_high_r;
    logic [PER_W-1:0] fix_per_r;
    logic [5:0] fsa_r;
    logic [5:0] fsb_r;
    logic [PER_W-1:0] fda_r;
    logic [PER_W-1:0] fdb_r;
    logic fca_r;
    logic fcb_r;

    // wake and interrupt
    logic [NPINS-1:0] sync1_r;
    logic [NPINS-1:0] sync2_r;
    logic [NPINS-1:0] wake_hit;
    logic [NPINS-1:0] stat_r;
    logic [NPINS-1:0] stat_nxt;
    logic [NPINS-1:0] mask_r;
    logic [NPINS-1:0] clr;

    // generator outputs and pin mux
    logic pwm_o;
    logic [FIX_OUTS-1:0] fix_o;
    logic [NPINS-1:0] fix_on;
    logic [NPINS-1:0] pin_nxt;
    logic [4:0] sel_cnt;

    // address phase taken when selected, active and the bus is ready
    assign acc = HSEL && HTRANS[1] && HREADY;

    // writes are zero wait; reads take one wait state so data comes from a flop
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            HREADYOUT <= 1'b1;
            adr_r <= '0;
        end else begin
            wr_pend_r <= acc && HWRITE && (HSIZE == 3'h2);
            if (acc) begin
                adr_r <= HADDR;
            end
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                HREADYOUT <= 1'b1;
            end else if (acc && !HWRITE) begin
                rd_pend_r <= 1'b1;
                HREADYOUT <= 1'b0;
            end
        end
    end

    // read data loaded in the wait cycle; this also sees a write just finished
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            if (rd_pend_r) begin
                HRDATA <= rdata;
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_r)
            OFS_DIR: rdata[NPINS-1:0] = dir_r;
            OFS_OUT: rdata[NPINS-1:0] = out_r;
            OFS_IN: rdata[NPINS-1:0] = sync2_r;
            OFS_DRIVE: rdata[NPINS-1:0] = drv_r;
            OFS_PULLUP: rdata[NPINS-1:0] = pu_r;
            OFS_PULLDN: rdata[NPINS-1:0] = pd_r;
            OFS_WAKE_EN: rdata[NPINS-1:0] = wen_r;
            OFS_WAKE_POL: rdata[NPINS-1:0] = wpol_r;
            OFS_PIN_FUNC_PWM: rdata[NPINS-1:0] = pwm_sel_r;
            OFS_PWM_PERIOD: rdata[PER_W-1:0] = pwm_per_r;
            OFS_PWM_HIGH: rdata[PER_W-1:0] = pwm_high_r;
            OFS_FIX_PERIOD: rdata[PER_W-1:0] = fix_per_r;
            OFS_FIX_SEL: rdata[FSEL_B_LSB+5:0] = {fsb_r, 2'h0, fsa_r};
            OFS_FIX_DUTY_A: begin
                rdata[PER_W-1:0] = fda_r;
                rdata[DUTY_CUS] = fca_r;
            end
            OFS_FIX_DUTY_B: begin
                rdata[PER_W-1:0] = fdb_r;
                rdata[DUTY_CUS] = fcb_r;
            end
            OFS_WAKE_STAT: rdata[NPINS-1:0] = stat_r;
            OFS_WAKE_MASK: rdata[NPINS-1:0] = mask_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // ones in a pwm routing write, to refuse more pins than the generator fans to
    always_comb begin
        sel_cnt = 5'h00;
        for (int k = 0; k < NPINS; k++) begin
            sel_cnt = sel_cnt + 5'(HWDATA[k]);
        end
    end

    // per-pin configuration registers, each pin independent
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dir_r <= RST_PINS;
            out_r <= RST_PINS;
            drv_r <= RST_PINS;
            pu_r <= RST_PINS;
            pd_r <= RST_PINS;
            wen_r <= RST_PINS;
            wpol_r <= RST_PINS;
            mask_r <= RST_PINS;
        end else if (wr_pend_r) begin
            case (adr_r)
                OFS_DIR: dir_r <= HWDATA[NPINS-1:0]; // [RQ1]
                OFS_OUT: out_r <= HWDATA[NPINS-1:0];
                OFS_DRIVE: drv_r <= HWDATA[NPINS-1:0]; // [RQ2]
                OFS_PULLUP: pu_r <= HWDATA[NPINS-1:0]; // [RQ3]
                OFS_PULLDN: pd_r <= HWDATA[NPINS-1:0]; // [RQ3]
                OFS_WAKE_EN: wen_r <= HWDATA[NPINS-1:0]; // [RQ4]
                OFS_WAKE_POL: wpol_r <= HWDATA[NPINS-1:0]; // [RQ4]
                OFS_WAKE_MASK: mask_r <= HWDATA[NPINS-1:0];
                default: ;
            endcase
        end
    end

    // generator settings and routing
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pwm_sel_r <= RST_PINS;
            pwm_per_r <= RST_PER;
            pwm_high_r <= RST_PER;
            fix_per_r <= RST_PER;
            fsa_r <= RST_FSEL;
            fsb_r <= RST_FSEL;
            fda_r <= RST_PER;
            fdb_r <= RST_PER;
            fca_r <= 1'b0;
            fcb_r <= 1'b0;
        end else if (wr_pend_r) begin
            case (adr_r)
                OFS_PIN_FUNC_PWM: begin
                    // an over-wide routing is dropped whole, old routing stays
                    if (sel_cnt <= 5'(PWM_MAX_PINS)) begin // [RQ5]
                        pwm_sel_r <= HWDATA[NPINS-1:0];
                    end
                end
                OFS_PWM_PERIOD: pwm_per_r <= HWDATA[PER_W-1:0]; // [RQ6]
                OFS_PWM_HIGH: pwm_high_r <= HWDATA[PER_W-1:0]; // [RQ7]
                OFS_FIX_PERIOD: fix_per_r <= HWDATA[PER_W-1:0]; // [RQ10]
                OFS_FIX_SEL: begin
                    // two selectors, so no more than two pins can carry it
                    fsa_r <= HWDATA[5:0]; // [RQ8]
                    fsb_r <= HWDATA[FSEL_B_LSB+5:FSEL_B_LSB]; // [RQ8]
                end
                OFS_FIX_DUTY_A: begin
                    fda_r <= HWDATA[PER_W-1:0]; // [RQ9]
                    fca_r <= HWDATA[DUTY_CUS];
                end
                OFS_FIX_DUTY_B: begin
                    fdb_r <= HWDATA[PER_W-1:0]; // [RQ9]
                    fcb_r <= HWDATA[DUTY_CUS];
                end
                default: ;
            endcase
        end
    end

    // pins are asynchronous to the clock: two flops before any use
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sync1_r <= RST_PINS;
            sync2_r <= RST_PINS;
        end else begin
            sync1_r <= PIN_IN;
            sync2_r <= sync1_r;
        end
    end

    // level match per enabled pin; a held level keeps re-setting its bit
    assign wake_hit = wen_r & ~(sync2_r ^ wpol_r); // [RQ4]
    assign clr = (wr_pend_r && adr_r == OFS_WAKE_STAT) ? HWDATA[NPINS-1:0] : RST_PINS;
    // a set in the clearing cycle wins over the write of one
    assign stat_nxt = (stat_r & ~clr) | wake_hit; // [RQ4]

    // sticky wake status, interrupt and wake request
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stat_r <= RST_PINS;
            IRQ <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            IRQ <= |(stat_r & mask_r);
            WAKE <= |wake_hit;
        end
    end

    gpf_pwm #(
        .W(PER_W)
    ) u_pwm (
        .clk(REF_CLK),
        .rst(RST),
        .period(pwm_per_r),
        .high(pwm_high_r),
        .pwm_o(pwm_o)
    );

    gpf_fixout #(
        .W(PER_W),
        .N(FIX_OUTS)
    ) u_fix (
        .clk(REF_CLK),
        .rst(RST),
        .period(fix_per_r),
        .cus({fcb_r, fca_r}),
        .high({fdb_r, fda_r}),
        .fix_o(fix_o)
    );

    // per-pin source: fixed-rate A, then B, then pwm, then plain output value
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        logic on_a;
        logic on_b;
        assign on_a = fsa_r[FSEL_EN] && (fsa_r[4:0] == 5'(i)); // [RQ8]
        assign on_b = fsb_r[FSEL_EN] && (fsb_r[4:0] == 5'(i)); // [RQ8]
        assign fix_on[i] = on_a || on_b;
        assign pin_nxt[i] = on_a ? fix_o[0] :
                            on_b ? fix_o[1] :
                            pwm_sel_r[i] ? pwm_o : out_r[i]; // [RQ11]
    end

    // pad controls; drive strength only means something on an output
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            PIN_OUT <= RST_PINS;
            PIN_OE <= RST_PINS;
            PIN_HIDRIVE <= RST_PINS;
            PIN_PULLUP <= RST_PINS;
            PIN_PULLDN <= RST_PINS;
        end else begin
            PIN_OUT <= pin_nxt; // [RQ11]
            PIN_OE <= dir_r; // [RQ1]
            PIN_HIDRIVE <= drv_r & dir_r; // [RQ2]
            PIN_PULLUP <= pu_r; // [RQ3]
            PIN_PULLDN <= pd_r & ~pu_r; // [RQ3]
        end
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence dir_wr_s;
        wr_pend_r && adr_r == OFS_DIR;
    endsequence

    sequence dir_quiet_s;
        dir_wr_s ##1 !(wr_pend_r && adr_r == OFS_DIR);
    endsequence

    dir_follow_a: assert property (dir_quiet_s |-> ##1 // [RQ1]
            PIN_OE == $past(HWDATA[NPINS-1:0], 2))
        else $error("direction write not on pins");
    drive_out_a: assert property ((PIN_HIDRIVE & ~PIN_OE) == '0) // [RQ2]
        else $error("high drive on an input pin");
    pull_excl_a: assert property ((PIN_PULLUP & PIN_PULLDN) == '0) // [RQ3]
        else $error("both pulls on one pin");
    wake_sticky_a: assert property ((wake_hit != '0) |=> // [RQ4]
            (stat_r & $past(wake_hit)) == $past(wake_hit))
        else $error("wake level did not set status");
    irq_level_a: assert property (((stat_r & mask_r) != '0) |=> IRQ)
        else $error("interrupt missing for unmasked status");
    pwm_cap_a: assert property ($countones(pwm_sel_r) <= PWM_MAX_PINS) // [RQ5]
        else $error("pwm routed to too many pins");
    fix_route_a: assert property ($countones(fix_on) <= FIX_OUTS) // [RQ8]
        else $error("fixed-rate output on too many pins");
    alt_drive_a: assert property ((pwm_sel_r[0] && !fix_on[0]) |=> // [RQ11]
            PIN_OUT[0] == $past(pwm_o))
        else $error("pwm pin not driven by generator");
    read_wait_a: assert property ((acc && !HWRITE && !rd_pend_r) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
endmodule

// ### verification/gpf_pin_load.sv
// gpf_pin_load: board side of the pin bank, outside drivers and pull resistors
`timescale 1ns/1ps
module gpf_pin_load
    import gpf_pkg::*;
(
    input wire logic clk,
    input wire logic [NPINS-1:0] pad_out,
    input wire logic [NPINS-1:0] pad_oe,
    input wire logic [NPINS-1:0] pull_up,
    input wire logic [NPINS-1:0] pull_dn,
    input wire logic [NPINS-1:0] ext_val,
    input wire logic [NPINS-1:0] ext_en,
    output logic [NPINS-1:0] pad_in
);
    logic [NPINS-1:0] float_r = 19'h0_0000;

    // an undriven, unpulled pad wanders; never let it hold a stale level
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end

    // device driver first, then the board driver, then the pulls
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pull_up[i] || pull_dn[i]) begin
                pad_in[i] = pull_up[i];
            end else begin
                pad_in[i] = float_r[i];
            end
        end
    end
endmodule

// ### verification/tb.sv
// tb: self-checking bench for the pin bank registers, wake logic and generators
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
    import gpf_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hready, hresp, irq, wake;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe, hidrv, pup, pdn;
    logic [NPINS-1:0] ext_val = 19'h0_0000;
    logic [NPINS-1:0] ext_en = 19'h0_0000;
    logic [NPINS-1:0] cfg [5];
    int num_errors = 0;
    int checked = 0;
    integer seed = 32'ha092;

    initial begin
        forever #25 clk = ~clk;
    end

    gpf_bank dut (.REF_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_HIDRIVE(hidrv), .PIN_PULLUP(pup),
        .PIN_PULLDN(pdn), .IRQ(irq), .WAKE(wake));

    gpf_pin_load load (.clk(clk), .pad_out(pin_out), .pad_oe(pin_oe), .pull_up(pup),
        .pull_dn(pdn), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pin_in));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bounded wait for hready; a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
    endtask

    // one single AHB-Lite transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            input logic [2:0] sz, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, 3'b010, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0000_0000, 3'b010, d);
        `CHK(d, e)
    endtask

    // count high cycles and rising edges of two pads, and edges that coincide
    task automatic measure(input int p, input int q, input int n, output int c[5]);
        logic lp, lq;
        c = '{0, 0, 0, 0, 0};
        lp = pin_out[p];
        lq = pin_out[q];
        repeat (n) begin
            @(posedge clk);
            #1;
            c[0] += (pin_out[p] === 1'b1);
            c[1] += (pin_out[p] === 1'b1 && lp === 1'b0);
            c[2] += (pin_out[q] === 1'b1);
            c[3] += (pin_out[q] === 1'b1 && lq === 1'b0);
            c[4] += (pin_out[p] === 1'b1 && lp === 1'b0 && pin_out[q] === 1'b1 && lq === 1'b0);
            lp = pin_out[p];
            lq = pin_out[q];
        end
    endtask

    // short periods are stretched to the fastest rate the generator allows
    function automatic int eff(input int p, input int lo);
        return (p < lo) ? lo : p;
    endfunction

    function automatic int hi_cnt(input int h, input int p, input int n);
        return (h >= p) ? n : h * (n / p);
    endfunction

    function automatic logic [NPINS-1:0] exp_in();
        return (cfg[0] & cfg[1]) | (~cfg[0] & ext_en & ext_val) | (~cfg[0] & ~ext_en & cfg[3]);
    endfunction

    initial begin
        logic [31:0] d;
        logic [NPINS-1:0] known;
        int c[5];
        int p, h, e;
        logic [7:0] ofs [5];
        int pw [5][2];
        ofs = '{OFS_DIR, OFS_OUT, OFS_DRIVE, OFS_PULLUP, OFS_PULLDN};
        pw = '{'{5, 7}, '{40, 0}, '{40, 10}, '{40, 40}, '{60, 30}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // every register but the input register reads zero after reset, pads released
        for (int a = 0; a <= 8'h44; a += 4) begin
            if (a != OFS_IN) rd_chk(a[7:0], 32'h0000_0000);
        end
        `CHK(pin_oe, RST_PINS)
        $display("test reset done");
        // random per-pin configuration, then pads and input readback
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 5; k++) begin
                cfg[k] = NPINS'($random(seed));
                wr(ofs[k], 32'(cfg[k]));
                rd_chk(ofs[k], 32'(cfg[k]));
            end
            ext_en <= NPINS'($random(seed));
            ext_val <= NPINS'($random(seed));
            repeat (4) @(posedge clk);
            #1;
            `CHK(pin_oe, cfg[0])
            `CHK(pin_out & cfg[0], cfg[1] & cfg[0])
            `CHK(hidrv, cfg[2] & cfg[0])
            `CHK(pup, cfg[3])
            `CHK(pdn, cfg[4] & ~cfg[3])
            known = cfg[0] | ext_en | cfg[3] | cfg[4];
            xfer(1'b0, OFS_IN, 32'h0000_0000, 3'b010, d);
            `CHK(d[NPINS-1:0] & known, exp_in() & known)
        end
        xfer(1'b1, OFS_OUT, ~32'(cfg[1]), 3'b000, d);
        rd_chk(OFS_OUT, 32'(cfg[1]));
        wr(8'h44, 32'hFFFF_FFFF);
        rd_chk(8'h44, 32'h0000_0000);
        $display("test config done");
        // level wake on pin 7, each polarity: status, irq, mask, clear
        wr(OFS_DIR, 32'h0000_0000);
        wr(OFS_PULLUP, 32'h0000_0000);
        wr(OFS_PULLDN, 32'h0000_0000);
        wr(OFS_WAKE_EN, 32'h0000_0080);
        ext_en <= 19'h7_FFFF;
        for (int pol = 0; pol < 2; pol++) begin
            ext_val <= pol ? 19'h0_0000 : 19'h7_FFFF;
            wr(OFS_WAKE_POL, pol ? 32'h0000_0080 : 32'h0000_0000);
            wr(OFS_WAKE_MASK, 32'h0000_0080);
            repeat (6) @(posedge clk);
            wr(OFS_WAKE_STAT, 32'h0000_0080);
            rd_chk(OFS_WAKE_STAT, 32'h0000_0000);
            `CHK({wake, irq}, 2'b00)
            ext_val <= pol ? 19'h0_0080 : 19'h7_FF7F;
            repeat (6) @(posedge clk);
            #1;
            `CHK({wake, irq}, 2'b11)
            rd_chk(OFS_WAKE_STAT, 32'h0000_0080);
            wr(OFS_WAKE_MASK, 32'h0000_0000);
            repeat (3) @(posedge clk);
            #1;
            `CHK({wake, irq}, 2'b10)
            ext_val <= pol ? 19'h0_0000 : 19'h7_FFFF;
            repeat (6) @(posedge clk);
            wr(OFS_WAKE_STAT, 32'h0000_0080);
            rd_chk(OFS_WAKE_STAT, 32'h0000_0000);
            `CHK(wake, 1'b0)
        end
        $display("test wake done");
        // pulse width output on twelve pins, thirteen refused
        wr(OFS_DIR, 32'h0007_FFFF);
        wr(OFS_OUT, 32'h0000_0004);
        wr(OFS_PIN_FUNC_PWM, 32'h0000_0FFF);
        rd_chk(OFS_PIN_FUNC_PWM, 32'h0000_0FFF);
        wr(OFS_PIN_FUNC_PWM, 32'h0000_1FFF);
        rd_chk(OFS_PIN_FUNC_PWM, 32'h0000_0FFF);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_PWM_PERIOD, 32'(pw[i][0]));
            wr(OFS_PWM_HIGH, 32'(pw[i][1]));
            repeat (130) @(posedge clk);
            measure(2, 11, 240, c);
            p = eff(pw[i][0], PWM_MIN_PER);
            h = pw[i][1];
            e = (h == 0 || h >= p) ? 0 : 240 / p;
            `CHK(c[1], e)
            `CHK(c[0], hi_cnt(h, p, 240))
            `CHK(c[2], c[0])
        end
        wr(OFS_PIN_FUNC_PWM, 32'h0000_0000);
        repeat (3) @(posedge clk);
        #1;
        `CHK(pin_out[2], 1'b1)
        $display("test pwm done");
        // fixed-rate outputs on pins 4 and 9: shared rate, own duty
        wr(OFS_OUT, 32'h0007_FFFF);
        wr(OFS_FIX_SEL, 32'h0000_2924);
        wr(OFS_FIX_DUTY_A, 32'h0000_0000);
        wr(OFS_FIX_DUTY_B, 32'h8000_0003);
        for (int i = 0; i < 4; i++) begin
            p = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 10 : 40;
            wr(OFS_FIX_PERIOD, 32'(p));
            repeat (100) @(posedge clk);
            measure(4, 9, 200, c);
            if (p == 0) begin
                `CHK(c[0] + c[1] + c[2] + c[3], 0)
            end else begin
                p = eff(p, FIX_MIN_PER);
                `CHK(c[1], 200 / p)
                `CHK(c[0], hi_cnt(p / 2, p, 200))
                `CHK(c[2], hi_cnt(3, p, 200))
                `CHK(c[4], 200 / p)
            end
        end
        $display("test fixed done");
        print_verdict();
    end
endmodule
